// ===== async_serial_display_port.sv
// Asynchronous serial display port: shifts command words out to a display
// panel over a 3-, 4- or 5-wire link and shifts read words back in.
// Assumes settings and mode are held stable while busy is high.
module async_serial_display_port
  import async_serial_display_port_pkg::*;
#(
  parameter int HALF_DIV = HALF_DIV_DEF
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire link_mode_e link_mode,
  input wire logic select_active_high,
  input wire logic clock_invert,
  input wire timing_s timing,
  input wire cmd_s cmd_data,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic serial_data_in,
  output logic serial_data_out,
  output logic serial_data_out_enable,
  output logic panel_select_n,
  output logic panel_serial_clock,
  output logic register_select,
  output logic [DATA_W-1:0] read_data,
  output logic read_valid,
  output logic busy
);

  localparam int DIV_W = $clog2(HALF_DIV + 1);
  localparam int BIT_W = $clog2(DATA_W);
  localparam int AW = SET_W + 2;

  if (HALF_DIV < 1 || DATA_W < 2) begin : g_check
    $error("HALF_DIV must be at least 1 and DATA_W at least 2");
  end

  // ==========================================================================
  // half interface clock period enable
  logic [DIV_W-1:0] div_q;
  logic tick_q;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= '0;
      tick_q <= 1'b0;
    end else if (div_q == DIV_W'(HALF_DIV - 1)) begin
      div_q <= '0;
      tick_q <= 1'b1;
    end else begin
      div_q <= div_q + 1'b1;
      tick_q <= 1'b0;
    end
  end

  // ==========================================================================
  // input synchroniser for the panel's read data
  logic sdi_meta_q;
  logic sdi_q;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sdi_meta_q <= 1'b0;
      sdi_q <= 1'b0;
    end else begin
      sdi_meta_q <= serial_data_in;
      sdi_q <= sdi_meta_q;
    end
  end

  // ==========================================================================
  // two-entry command buffer; a stalled link backs up into cmd_ready
  cmd_s buf_mem [FIFO_DEPTH];
  logic wr_ptr_q;
  logic rd_ptr_q;
  logic [1:0] count_q;
  logic [1:0] count_d;
  logic push;
  logic pop;
  port_state_e state_q;

  assign push = cmd_valid && cmd_ready;
  assign pop = (state_q == ST_IDLE) && (count_q != 2'h0);

  always_comb begin
    count_d = count_q;
    if (push && !pop) begin
      count_d = count_q + 2'h1;
    end else if (pop && !push) begin
      count_d = count_q - 2'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (push) begin
      buf_mem[wr_ptr_q] <= cmd_data;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      count_q <= 2'h0;
      cmd_ready <= 1'b0;
    end else begin
      wr_ptr_q <= wr_ptr_q ^ push;
      rd_ptr_q <= rd_ptr_q ^ pop;
      count_q <= count_d;
      cmd_ready <= count_d != 2'(FIFO_DEPTH);
    end
  end

  // ==========================================================================
  // access timer: facc counts floor(k/2)*p, cacc counts p per half period after offset
  cmd_s cur_q;
  logic [BIT_W-1:0] bit_q;
  logic [AW-1:0] facc_q;
  logic [AW-1:0] cacc_q;
  logic odd_q;
  logic sampled_q;
  logic [DATA_W-1:0] shift_q;
  logic [AW-1:0] per;
  logic [SET_W-1:0] size;
  logic [SET_W-1:0] rise;
  logic [SET_W-1:0] fall;
  logic first_bit;
  logic last_bit;
  logic done;
  logic clk_run;
  logic do_sample;

  // a zero period would freeze the counters, so it is served as one unit
  assign per = (timing.clock_period_setting == '0) ? AW'(1) : AW'(timing.clock_period_setting);
  assign size = cur_q.is_read ? timing.read_size_setting : timing.write_size_setting;
  assign rise = cur_q.is_read ? timing.read_clock_rise_setting : timing.write_clock_rise_setting;
  assign fall = cur_q.is_read ? timing.read_clock_fall_setting : timing.write_clock_fall_setting;
  assign first_bit = bit_q == BIT_W'(DATA_W - 1);
  assign last_bit = bit_q == '0;
  // done marks the last half period, so an access spans 2*ceil(size/p) of them, or 2 when size is 0
  assign done = odd_q && (facc_q + per >= AW'(size));
  assign clk_run = facc_q >= AW'(timing.clock_offset_setting);
  assign do_sample = cur_q.is_read && !sampled_q &&
                     (done || facc_q >= AW'(timing.read_sample_point_setting));

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      cur_q <= '0;
      bit_q <= '0;
      facc_q <= '0;
      cacc_q <= '0;
      odd_q <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (pop) begin
            state_q <= ST_ACCESS;
            cur_q <= buf_mem[rd_ptr_q];
            bit_q <= BIT_W'(DATA_W - 1);
            facc_q <= '0;
            cacc_q <= '0;
            odd_q <= 1'b0;
          end
        end
        ST_ACCESS: begin
          if (tick_q) begin
            if (done) begin
              facc_q <= '0;
              cacc_q <= '0;
              odd_q <= 1'b0;
              bit_q <= bit_q - 1'b1;
              if (last_bit) begin
                state_q <= ST_IDLE;
              end
            end else begin
              odd_q <= !odd_q;
              if (odd_q) begin
                facc_q <= facc_q + per;
              end
              if (clk_run) begin
                cacc_q <= cacc_q + per;
              end
            end
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // read shifter, msb first
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sampled_q <= 1'b0;
      shift_q <= '0;
      read_data <= '0;
      read_valid <= 1'b0;
    end else begin
      read_valid <= 1'b0;
      if (state_q == ST_ACCESS && tick_q) begin
        if (do_sample) begin
          shift_q <= {shift_q[DATA_W-2:0], sdi_q};
        end
        sampled_q <= done ? 1'b0 : (sampled_q || do_sample);
        if (done && last_bit && cur_q.is_read) begin
          read_data <= do_sample ? {shift_q[DATA_W-2:0], sdi_q} : shift_q;
          read_valid <= 1'b1;
        end
      end
    end
  end

  // ==========================================================================
  // link outputs, computed per half period and registered
  logic sel_on;
  logic rs_on;
  logic clk_low;
  logic sel_d;
  logic sclk_d;
  logic sdo_d;
  logic oe_d;
  logic rs_d;
  logic active;

  assign active = state_q == ST_ACCESS;

  always_comb begin
    // chip select spans the word: asserts in the first access, releases in the last
    sel_on = (!first_bit || facc_q >= AW'(timing.select_assert_setting)) &&
             (!last_bit || facc_q < AW'(timing.select_release_setting));
    if (link_mode == LINK_5WIRE_SEL) begin
      rs_on = (!first_bit || facc_q >= AW'(timing.regsel_assert_setting)) &&
              (!last_bit || facc_q < AW'(timing.regsel_release_setting));
    end else begin
      rs_on = facc_q >= AW'(timing.regsel_assert_setting) &&
              facc_q < AW'(timing.regsel_release_setting);
    end
    // half-period compare realises ceil(2*x/p) half periods
    clk_low = clk_run && cacc_q >= AW'({rise, 1'b0}) &&
              cacc_q < AW'({fall, 1'b0});
    sel_d = select_active_high ? 1'b0 : 1'b1;
    sclk_d = CLK_IDLE ^ clock_invert;
    sdo_d = IDLE_DATA;
    oe_d = (link_mode == LINK_3WIRE) ? OE_RELEASED : OE_DRIVING;
    rs_d = RS_IDLE;
    if (active) begin
      sel_d = sel_on ^ !select_active_high;
      sclk_d = (clk_low ? 1'b0 : 1'b1) ^ clock_invert;
      if (!cur_q.is_read) begin
        sdo_d = cur_q.data[bit_q];
      end
      if (link_mode == LINK_3WIRE) begin
        oe_d = cur_q.is_read ? OE_RELEASED : OE_DRIVING;
      end
      if (link_mode == LINK_5WIRE_CLK || link_mode == LINK_5WIRE_SEL) begin
        rs_d = rs_on && cur_q.regsel;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      panel_select_n <= 1'b1;
      panel_serial_clock <= CLK_IDLE;
      serial_data_out <= IDLE_DATA;
      serial_data_out_enable <= OE_RELEASED;
      register_select <= RS_IDLE;
      busy <= 1'b0;
    end else begin
      if (tick_q || state_q == ST_IDLE) begin
        panel_select_n <= sel_d;
        panel_serial_clock <= sclk_d;
        serial_data_out <= sdo_d;
        serial_data_out_enable <= oe_d;
        register_select <= rs_d;
      end
      busy <= (state_q == ST_ACCESS) || (count_q != 2'h0);
    end
  end

endmodule

// ===== async_serial_display_port_pkg.sv
// Shared types and constants of the asynchronous serial display port.
// Assumes a single system clock; all settings are unsigned counts of setting units.
package async_serial_display_port_pkg;

  // ==========================================================================
  // sizes and defaults
  localparam int DATA_W = 8;
  localparam int SET_W = 8;
  localparam int HALF_DIV_DEF = 1;
  localparam int FIFO_DEPTH = 2;

  // ==========================================================================
  // idle levels of the link outputs
  localparam logic IDLE_DATA = 1'b0;
  localparam logic OE_RELEASED = 1'b1;
  localparam logic OE_DRIVING = 1'b0;
  localparam logic RS_IDLE = 1'b0;
  localparam logic CLK_IDLE = 1'b1;

  // ==========================================================================
  // modes and states
  typedef enum logic [1:0] {
    LINK_3WIRE = 2'h0,
    LINK_4WIRE = 2'h1,
    LINK_5WIRE_CLK = 2'h2,
    LINK_5WIRE_SEL = 2'h3
  } link_mode_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_ACCESS = 2'b10
  } port_state_e;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic is_read;
    logic regsel;
    logic [DATA_W-1:0] data;
  } cmd_s;

  typedef struct packed {
    logic [SET_W-1:0] clock_period_setting;
    logic [SET_W-1:0] read_size_setting;
    logic [SET_W-1:0] write_size_setting;
    logic [SET_W-1:0] read_clock_rise_setting;
    logic [SET_W-1:0] read_clock_fall_setting;
    logic [SET_W-1:0] write_clock_rise_setting;
    logic [SET_W-1:0] write_clock_fall_setting;
    logic [SET_W-1:0] clock_offset_setting;
    logic [SET_W-1:0] regsel_assert_setting;
    logic [SET_W-1:0] regsel_release_setting;
    logic [SET_W-1:0] select_assert_setting;
    logic [SET_W-1:0] select_release_setting;
    logic [SET_W-1:0] read_sample_point_setting;
  } timing_s;

endpackage

// ===== async_serial_display_port_properties.sv
// ==========
// checker for the serial display port
// assumes polarity inputs change only while idle
module async_serial_display_port_properties
  import async_serial_display_port_pkg::*;
#(
  parameter int HALF_DIV = HALF_DIV_DEF
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire link_mode_e link_mode,
  input wire logic select_active_high,
  input wire logic clock_invert,
  input wire timing_s timing,
  input wire logic cmd_ready,
  input wire logic serial_data_out_enable,
  input wire logic panel_select_n,
  input wire logic panel_serial_clock,
  input wire logic register_select,
  input wire logic read_valid,
  input wire logic busy
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic [15:0] low_q;
  logic [15:0] low_d;
  logic clk_lo;
  logic inv_q;
  int rd_lo;
  int wr_lo;
  function automatic int hp(input logic [SET_W-1:0] s, input logic [SET_W-1:0] p);
    int q;
    q = (p == '0) ? 1 : int'(p);
    return HALF_DIV * ((2 * int'(s) + q - 1) / q);
  endfunction
  // the clock pin follows the invert input one edge late, so compare with a delayed copy
  assign clk_lo = (panel_serial_clock ^ inv_q) != CLK_IDLE;
  assign low_d = clk_lo ? low_q + 16'h0001 : 16'h0000;
  assign rd_lo = hp(timing.read_clock_fall_setting, timing.clock_period_setting)
    - hp(timing.read_clock_rise_setting, timing.clock_period_setting);
  assign wr_lo = hp(timing.write_clock_fall_setting, timing.clock_period_setting)
    - hp(timing.write_clock_rise_setting, timing.clock_period_setting);
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      low_q <= '0;
      inv_q <= 1'b0;
    end else begin
      low_q <= low_d;
      inv_q <= clock_invert;
    end
  end
  sequence s_idle2;
    !busy ##1 !busy;
  endsequence
  a_oe_mode: assert property (
    $past(rst_n) && $stable(link_mode) && link_mode != LINK_3WIRE
    |-> serial_data_out_enable == OE_DRIVING) else $error("oe released in 4/5-wire");
  a_rs_mode: assert property (
    $past(rst_n) && $stable(link_mode) && link_mode inside {LINK_3WIRE, LINK_4WIRE}
    |-> register_select == RS_IDLE) else $error("rs driven without rs line");
  a_clock_idle: assert property (
    s_idle2 ##0 $stable(clock_invert) |-> panel_serial_clock == (CLK_IDLE ^ clock_invert))
    else $error("clock not idle");
  a_select_idle: assert property (
    s_idle2 ##0 $stable(select_active_high) |-> panel_select_n == !select_active_high)
    else $error("select active while idle");
  a_valid_pulse: assert property (
    read_valid |=> !read_valid) else $error("read_valid too long");
  a_low_width: assert property (
    $fell(clk_lo) |-> int'(low_q) inside {rd_lo, wr_lo}) else $error("clock low width");
  a_full_busy: assert property (
    $past(rst_n) && !cmd_ready |-> busy) else $error("refusing while idle");
  a_rs_in_select: assert property (
    register_select != RS_IDLE |-> panel_select_n == select_active_high)
    else $error("rs outside select");
endmodule

bind async_serial_display_port async_serial_display_port_properties
  #(.HALF_DIV(HALF_DIV)) u_props (.*);

// ===== serial_panel_model.sv
// ==========
// behavioural serial panel: shifts in written bits, returns one read word
// assumes the bench flags read words and the clock is straight
module serial_panel_model
  import async_serial_display_port_pkg::*;
(
  input wire logic sel_n,
  input wire logic active_high,
  input wire logic sclk,
  input wire logic line_in,
  input wire logic reading,
  input wire logic [DATA_W-1:0] tx_word,
  output logic line_out,
  output logic [4*DATA_W-1:0] rx_word
);
  timeunit 1ns;
  timeprecision 1ns;
  logic sel;
  logic [$clog2(DATA_W)-1:0] idx;
  assign sel = sel_n == active_high;
  initial begin
    line_out = 1'b0;
    rx_word = '0;
    idx = '1;
  end
  always @(posedge sclk) begin
    if (sel && !reading) rx_word <= {rx_word[4*DATA_W-2:0], line_in};
  end
  // bits change after a fall so they settle well before the sample point
  always @(negedge sclk or negedge sel) begin
    if (!sel) begin
      idx <= '1;
      line_out <= ~line_out; // released line flips its last bit
    end else if (reading) begin
      line_out <= tx_word[idx];
      idx <= idx - 1'b1;
    end
  end
endmodule

// ===== async_serial_display_port_bench.sv
// ==========
// self-checking bench for the serial display port in all link modes
// assumes serial_panel_model on the far side, one cycle per half period
module async_serial_display_port_bench
  import async_serial_display_port_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int P = 1;
  logic sys_clk, rst_n, sel_hi, cmd_valid, cmd_ready, sdi, sdo, oe, sel_n, sclk, rs, rv, busy;
  logic reading, p_line, prev_clk, rs_seen, full_seen, oe_wr, oe_rd, clk_inv;
  link_mode_e link_mode;
  timing_s timing;
  cmd_s cmd_data;
  logic [DATA_W-1:0] read_data, tx_word;
  logic [4*DATA_W-1:0] rx_word;
  int bad_count = 0;
  int checks_done = 0;
  int lo_cnt, lo_len, gap_cnt, fall_gap, rv_cnt, lo_w, lo_r, gw, gr;
  async_serial_display_port #(.HALF_DIV(1)) u_async_serial_display_port (
    .sys_clk(sys_clk), .rst_n(rst_n), .link_mode(link_mode), .select_active_high(sel_hi),
    .clock_invert(clk_inv), .timing(timing), .cmd_data(cmd_data), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .serial_data_in(sdi), .serial_data_out(sdo),
    .serial_data_out_enable(oe), .panel_select_n(sel_n), .panel_serial_clock(sclk),
    .register_select(rs), .read_data(read_data), .read_valid(rv), .busy(busy));
  // the model expects a straight clock, so an inverted pin is turned back here
  serial_panel_model u_serial_panel_model (.sel_n(sel_n), .active_high(sel_hi),
    .sclk(sclk ^ clk_inv), .line_in(sdo), .reading(reading), .tx_word(tx_word),
    .line_out(p_line), .rx_word(rx_word));
  assign sdi = (link_mode == LINK_3WIRE && oe == OE_DRIVING) ? sdo : p_line;
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    prev_clk <= sclk;
    lo_cnt <= sclk ? 0 : lo_cnt + 1;
    gap_cnt <= gap_cnt + 1;
    if (prev_clk && !sclk) begin
      fall_gap <= gap_cnt;
      gap_cnt <= 1;
    end
    if (!prev_clk && sclk) begin
      lo_len <= lo_cnt;
      if (reading) oe_rd <= oe;
      else oe_wr <= oe;
    end
    if (rs) rs_seen <= 1'b1;
    if (rv) rv_cnt <= rv_cnt + 1;
    if (rst_n && !cmd_ready) full_seen <= 1'b1;
  end
  function automatic int hp(input logic [SET_W-1:0] s);
    return (2 * int'(s) + P - 1) / P;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic send(input logic rd, input logic rsel, input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    cmd_data <= '{rd, rsel, d};
    cmd_valid <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (cmd_ready !== 1'b1 && n < 3000);
    if (n >= 3000) check(n, 32'h0);
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    cmd_valid <= 1'b0;
    repeat (4) @(posedge sys_clk);
    while (busy !== 1'b0 && n < 3000) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 3000) check(n, 32'h0);
    repeat (3) @(posedge sys_clk);
  endtask
  task automatic rd_word(input logic [DATA_W-1:0] w);
    reading <= 1'b1;
    tx_word <= w;
    rv_cnt <= 0;
    send(1'b1, 1'b0, 8'h00);
    wait_idle();
    reading <= 1'b0;
    check(read_data, w);
    check(rv_cnt, 1);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    rst_n = 1'b0;
    sel_hi = 1'b0;
    clk_inv = 1'b0;
    cmd_valid = 1'b0;
    cmd_data = '0;
    reading = 1'b0;
    tx_word = 8'h00;
    link_mode = LINK_3WIRE;
    timing = '{8'h01, 8'h06, 8'h04, 8'h01, 8'h02, 8'h01, 8'h02, 8'h00, 8'h00, 8'h02, 8'h00,
      8'h06, 8'h05};
    lo_w = hp(timing.write_clock_fall_setting) - hp(timing.write_clock_rise_setting);
    lo_r = hp(timing.read_clock_fall_setting) - hp(timing.read_clock_rise_setting);
    gw = 2 * ((int'(timing.write_size_setting) + P - 1) / P);
    gr = 2 * ((int'(timing.read_size_setting) + P - 1) / P);
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    check(sel_n, 1'b1);
    check(sclk, 1'b1);
    for (int m = 0; m < 4; m++) begin
      link_mode <= link_mode_e'(m);
      rs_seen <= 1'b0;
      send(1'b0, 1'b1, 8'hA5);
      wait_idle();
      check(rx_word[DATA_W-1:0], 8'hA5);
      check(lo_len, lo_w);
      check(fall_gap, gw);
      check(rs_seen, m >= 2);
      check(oe_wr, OE_DRIVING);
      rd_word(8'h3C ^ 8'(m));
      check(lo_len, lo_r);
      check(fall_gap, gr);
      check(oe_rd, m == 0 ? OE_RELEASED : OE_DRIVING);
    end
    // four words back to back fill the two-entry buffer
    link_mode <= LINK_4WIRE;
    full_seen <= 1'b0;
    send(1'b0, 1'b0, 8'h11);
    send(1'b0, 1'b0, 8'h22);
    send(1'b0, 1'b0, 8'h33);
    send(1'b0, 1'b0, 8'h44);
    wait_idle();
    check(full_seen, 1'b1);
    check(rx_word, 32'h11223344);
    sel_hi <= 1'b1;
    repeat (3) @(posedge sys_clk);
    check(sel_n, 1'b0);
    link_mode <= LINK_5WIRE_SEL;
    rd_word(8'h96);
    // inverted clock: idle level flips and a write still lands
    clk_inv <= 1'b1;
    repeat (3) @(posedge sys_clk);
    check(sclk, 1'b0);
    send(1'b0, 1'b0, 8'h5A);
    wait_idle();
    check(rx_word[DATA_W-1:0], 8'h5A);
    end_sim();
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    check(32'h0, 32'h1);
    end_sim();
  end
endmodule
